// ===== verilog/bdi_pkg.sv
// shared constants and types for the bus inversion coder ends
package bdi_pkg;

  // ***********************************************
  // bus geometry
  // ***********************************************
  localparam int DATA_W = 64;
  localparam int GRP_W = 16;
  localparam int NGRP = DATA_W / GRP_W;
  // transfers per common bus clock (quad pumped)
  localparam int SLOTS = 4;

  // ***********************************************
  // counter codes and idle levels
  // ***********************************************
  localparam logic [2:0] SLOT_ZERO = 3'h0;
  localparam logic [2:0] SLOT_ONE = 3'h1;
  localparam logic [2:0] SLOT_END = 3'h4;
  localparam logic PHASE_SET = 1'h0;
  localparam logic PHASE_FIRE = 1'h1;
  // active-low lines float high when nobody drives them
  localparam logic LINE_IDLE = 1'h1;

  // ***********************************************
  // transmit sequencer states
  // ***********************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_XFER = 3'h4
  } bdi_tx_st_t;

endpackage

// ===== verilog/bdi_link_if.sv
// shared data bus between the processor end and the peer agent end
`timescale 1ns/100ps
interface bdi_link_if;

  // ***********************************************
  // per-end drive (out value, enable)
  // ***********************************************
  logic bus_clk;
  logic [bdi_pkg::DATA_W-1:0] cpu_data_n, agt_data_n;
  logic [bdi_pkg::NGRP-1:0] cpu_flag_n, agt_flag_n;
  logic [bdi_pkg::NGRP-1:0] cpu_stbp_n, agt_stbp_n;
  logic [bdi_pkg::NGRP-1:0] cpu_stbn_n, agt_stbn_n;
  logic cpu_occ_n, agt_occ_n;
  logic cpu_vld_n, agt_vld_n;
  logic cpu_oe, agt_oe;
  logic agt_out_of_order_notice_n_n;

  // ***********************************************
  // resolved wire levels
  // ***********************************************
  // wired-and: an undriven active-low line reads high
  logic [bdi_pkg::DATA_W-1:0] data_line_n;
  logic [bdi_pkg::NGRP-1:0] group_invert_flag_n;
  logic [bdi_pkg::NGRP-1:0] group_strobe_pos_n;
  logic [bdi_pkg::NGRP-1:0] group_strobe_neg_n;
  logic data_bus_occupied_n;
  logic transfer_valid_n;
  logic out_of_order_notice_n;

  assign data_line_n = (cpu_oe ? cpu_data_n : '1) & (agt_oe ? agt_data_n : '1);
  assign group_invert_flag_n = (cpu_oe ? cpu_flag_n : '1)
                             & (agt_oe ? agt_flag_n : '1);
  assign group_strobe_pos_n = (cpu_oe ? cpu_stbp_n : '1)
                            & (agt_oe ? agt_stbp_n : '1);
  assign group_strobe_neg_n = (cpu_oe ? cpu_stbn_n : '1)
                            & (agt_oe ? agt_stbn_n : '1);
  assign data_bus_occupied_n = (cpu_oe ? cpu_occ_n : 1'b1)
                             & (agt_oe ? agt_occ_n : 1'b1);
  assign transfer_valid_n = (cpu_oe ? cpu_vld_n : 1'b1)
                          & (agt_oe ? agt_vld_n : 1'b1);
  assign out_of_order_notice_n = agt_out_of_order_notice_n_n;

  modport cpu_mp (
    input bus_clk, data_line_n, group_invert_flag_n, group_strobe_pos_n,
    input group_strobe_neg_n, data_bus_occupied_n, transfer_valid_n,
    input out_of_order_notice_n,
    output cpu_data_n, cpu_flag_n, cpu_stbp_n, cpu_stbn_n, cpu_occ_n,
    output cpu_vld_n, cpu_oe
  );

  modport agt_mp (
    input bus_clk, data_line_n, group_invert_flag_n, group_strobe_pos_n,
    input group_strobe_neg_n, data_bus_occupied_n, transfer_valid_n,
    output agt_data_n, agt_flag_n, agt_stbp_n, agt_stbn_n, agt_occ_n,
    output agt_vld_n, agt_oe, agt_out_of_order_notice_n_n
  );

endinterface

// ===== verilog/bdi_cpu_end.sv
// transfer engine shared by both ends, and the processor end
//
// How it works
// - 64 lines form four 16-line groups, one flag each
// - flag 3..0 cover bits 63:48 down to 15:0
// - active flag means group sent complemented
// - invert when over half the lines would toggle
// - flag travels in the same slot as its data
// - owner holds busy low while on the bus
// - start driving only after busy goes high
// - peer drives out_of_order_notice_n; processor only listens
// - four transfers per common bus clock
// - latch on falling edges of both strobes
// - valid low on clocks carrying data
`timescale 1ns/100ps
module bdi_xfer_core #(
  parameter int NGRP = bdi_pkg::NGRP,
  parameter int GRP_W = bdi_pkg::GRP_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link levels seen on the wires
  input wire logic bus_clk,
  input wire logic [NGRP*GRP_W-1:0] in_data_n,
  input wire logic [NGRP-1:0] in_flag_n,
  input wire logic [NGRP-1:0] in_stbp_n,
  input wire logic [NGRP-1:0] in_stbn_n,
  input wire logic in_occ_n,
  input wire logic in_vld_n,
  // link drive
  output logic [NGRP*GRP_W-1:0] out_data_n,
  output logic [NGRP-1:0] out_flag_n,
  output logic [NGRP-1:0] out_stbp_n,
  output logic [NGRP-1:0] out_stbn_n,
  output logic out_occ_n,
  output logic out_vld_n,
  output logic out_oe,
  // user transmit side
  input wire logic tx_valid,
  input wire logic [NGRP*GRP_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // user receive side
  output logic [NGRP*GRP_W-1:0] rx_data,
  output logic rx_valid
);

  localparam int W = NGRP * GRP_W;

  initial
  begin
    if (NGRP < 1 || GRP_W < 2 || W != bdi_pkg::DATA_W)
      $error("bdi_xfer_core: group layout must cover the data bus");
  end

  function automatic int ones(input logic [GRP_W-1:0] v);
    int n;
    n = 0;
    for (int i = 0; i < GRP_W; i++)
      n = n + int'(v[i]);
    return n;
  endfunction

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [W-1:0] d_s1_reg, d_s2_reg;
  logic [NGRP-1:0] f_s1_reg, f_s2_reg;
  logic [NGRP-1:0] p_s1_reg, p_s2_reg, p_s3_reg;
  logic [NGRP-1:0] n_s1_reg, n_s2_reg, n_s3_reg;
  logic [2:0] c_s1_reg, c_s2_reg;
  logic bclk_s3_reg, own_s1_reg, own_s2_reg;

  // all stages reset high, the own enable and the bus clock bit too, so no
  // false rise shows before the first real one
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {d_s1_reg, d_s2_reg, f_s1_reg, f_s2_reg} <= '1;
      {p_s1_reg, p_s2_reg, p_s3_reg, n_s1_reg, n_s2_reg, n_s3_reg} <= '1;
      {c_s1_reg, c_s2_reg, bclk_s3_reg, own_s1_reg, own_s2_reg} <= '1;
    end
    else
    begin
      {d_s2_reg, d_s1_reg} <= {d_s1_reg, in_data_n};
      {f_s2_reg, f_s1_reg} <= {f_s1_reg, in_flag_n};
      {p_s3_reg, p_s2_reg, p_s1_reg} <= {p_s2_reg, p_s1_reg, in_stbp_n};
      {n_s3_reg, n_s2_reg, n_s1_reg} <= {n_s2_reg, n_s1_reg, in_stbn_n};
      {c_s2_reg, c_s1_reg} <= {c_s1_reg, bus_clk, in_occ_n, in_vld_n};
      bclk_s3_reg <= c_s2_reg[2];
      // own enable delayed like the wires, so the tail of our own
      // transfer is never taken for received data
      {own_s2_reg, own_s1_reg} <= {own_s1_reg, out_oe};
    end
  end

  logic bus_rise, occ_s, vld_s;
  assign bus_rise = c_s2_reg[2] & ~bclk_s3_reg;
  assign occ_s = c_s2_reg[1];
  assign vld_s = c_s2_reg[0];

  // ***********************************************
  // transmit sequencer
  // ***********************************************
  bdi_pkg::bdi_tx_st_t state_reg, state_next;
  logic [2:0] slot_reg;
  logic phase_reg, live_reg, done_reg, took_reg, rise_reg, take;
  logic [W-1:0] line_reg, enc_line;
  logic [NGRP-1:0] flag_reg, enc_flag_n;

  assign take = (state_reg == bdi_pkg::ST_XFER) && live_reg && !done_reg
             && phase_reg == bdi_pkg::PHASE_SET
             && slot_reg != bdi_pkg::SLOT_END && tx_valid;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bdi_pkg::ST_IDLE:
        if (tx_valid && occ_s)
          state_next = bdi_pkg::ST_WAIT;
      bdi_pkg::ST_WAIT:
        if (bus_rise)
          state_next = bdi_pkg::ST_XFER;
      bdi_pkg::ST_XFER:
        if (bus_rise && done_reg)
          state_next = bdi_pkg::ST_IDLE;
      default:
        state_next = bdi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= bdi_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // each bus clock splits into four slots of set and fire phases
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_reg <= bdi_pkg::SLOT_END;
      phase_reg <= bdi_pkg::PHASE_SET;
    end
    else if (bus_rise)
    begin
      slot_reg <= bdi_pkg::SLOT_ZERO;
      phase_reg <= bdi_pkg::PHASE_SET;
    end
    else if (slot_reg != bdi_pkg::SLOT_END)
    begin
      phase_reg <= ~phase_reg;
      if (phase_reg == bdi_pkg::PHASE_FIRE)
        slot_reg <= slot_reg + bdi_pkg::SLOT_ONE;
    end
  end

  // bus ownership: busy, valid and the shared enable; they trail the
  // state by one clock, because the fourth strobe falls on the next
  // bus clock rise and must still go out under busy and valid
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_oe <= 1'h0;
      out_occ_n <= bdi_pkg::LINE_IDLE;
      out_vld_n <= bdi_pkg::LINE_IDLE;
      live_reg <= 1'h0;
      done_reg <= 1'h0;
      rise_reg <= 1'h0;
    end
    else
    begin
      rise_reg <= bus_rise;
      out_oe <= state_reg != bdi_pkg::ST_IDLE;
      out_occ_n <= state_reg == bdi_pkg::ST_IDLE;
      if (state_reg == bdi_pkg::ST_IDLE)
        out_vld_n <= bdi_pkg::LINE_IDLE;
      else if (rise_reg)
        out_vld_n <= ~live_reg;
      if (state_next == bdi_pkg::ST_IDLE)
      begin
        live_reg <= 1'h0;
        done_reg <= 1'h0;
      end
      else
      begin
        // no word ready at the clock edge: insert an idle clock
        if (bus_rise)
          live_reg <= tx_valid;
        if (take && tx_last)
          done_reg <= 1'h1;
      end
    end
  end

  // ***********************************************
  // inversion encoder, one per group
  // ***********************************************
  for (genvar g = 0; g < NGRP; g++)
  begin : g_enc
    logic [GRP_W-1:0] norm, diff;
    logic inv;
    assign norm = ~tx_data[g*GRP_W +: GRP_W];
    assign diff = norm ^ line_reg[g*GRP_W +: GRP_W];
    assign inv = ones(diff) > GRP_W / 2;
    assign enc_line[g*GRP_W +: GRP_W] = inv ? ~norm : norm;
    assign enc_flag_n[g] = ~inv;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_reg <= '1;
      flag_reg <= '1;
    end
    else if (state_reg == bdi_pkg::ST_IDLE)
    begin
      // after release the lines float back to their idle level
      line_reg <= '1;
      flag_reg <= '1;
    end
    else if (take)
    begin
      line_reg <= enc_line;
      flag_reg <= enc_flag_n;
    end
  end

  assign out_data_n = line_reg;
  assign out_flag_n = flag_reg;

  // strobes: even slots fall on pos, odd on neg; re-armed at set phase
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_stbp_n <= '1;
      out_stbn_n <= '1;
      took_reg <= 1'h0;
      tx_ready <= 1'h0;
    end
    else
    begin
      took_reg <= take;
      tx_ready <= take;
      if (state_reg == bdi_pkg::ST_IDLE)
      begin
        out_stbp_n <= '1;
        out_stbn_n <= '1;
      end
      else if (take && !slot_reg[0])
        out_stbp_n <= '1;
      else if (take)
        out_stbn_n <= '1;
      else if (took_reg && !slot_reg[0])
        out_stbp_n <= '0;
      else if (took_reg)
        out_stbn_n <= '0;
    end
  end

  // ***********************************************
  // receive decoder, one per group
  // ***********************************************
  logic [NGRP-1:0] grp_fall;
  logic listen;
  assign listen = state_reg == bdi_pkg::ST_IDLE && !own_s2_reg && !vld_s;

  for (genvar g = 0; g < NGRP; g++)
  begin : g_dec
    assign grp_fall[g] = (p_s3_reg[g] & ~p_s2_reg[g])
                       | (n_s3_reg[g] & ~n_s2_reg[g]);
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        rx_data[g*GRP_W +: GRP_W] <= '0;
      else if (listen && grp_fall[g])
        rx_data[g*GRP_W +: GRP_W] <= f_s2_reg[g]
          ? ~d_s2_reg[g*GRP_W +: GRP_W]
          : d_s2_reg[g*GRP_W +: GRP_W];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_valid <= 1'h0;
    else
      rx_valid <= listen && (|grp_fall);
  end

endmodule

// processor end: engine on the cpu side of the link plus out_of_order_notice_n sense
module bdi_cpu_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  bdi_link_if.cpu_mp link,
  // user transmit side
  input wire logic tx_valid,
  input wire logic [bdi_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // user receive side
  output logic [bdi_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  // out_of_order_notice_n notice, active high
  output logic out_of_order_notice_n_seen
);

  bdi_xfer_core u_core (
    .clk(clk),
    .rst_b(rst_b),
    .bus_clk(link.bus_clk),
    .in_data_n(link.data_line_n),
    .in_flag_n(link.group_invert_flag_n),
    .in_stbp_n(link.group_strobe_pos_n),
    .in_stbn_n(link.group_strobe_neg_n),
    .in_occ_n(link.data_bus_occupied_n),
    .in_vld_n(link.transfer_valid_n),
    .out_data_n(link.cpu_data_n),
    .out_flag_n(link.cpu_flag_n),
    .out_stbp_n(link.cpu_stbp_n),
    .out_stbn_n(link.cpu_stbn_n),
    .out_occ_n(link.cpu_occ_n),
    .out_vld_n(link.cpu_vld_n),
    .out_oe(link.cpu_oe),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  // out_of_order_notice_n is only ever received here
  logic dfr_s1_reg, dfr_s2_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dfr_s1_reg <= bdi_pkg::LINE_IDLE;
      dfr_s2_reg <= bdi_pkg::LINE_IDLE;
      out_of_order_notice_n_seen <= 1'h0;
    end
    else
    begin
      dfr_s1_reg <= link.out_of_order_notice_n;
      dfr_s2_reg <= dfr_s1_reg;
      out_of_order_notice_n_seen <= ~dfr_s2_reg;
    end
  end

endmodule

// ===== verilog/bdi_agent_end.sv
// peer memory/io agent end: same transfer engine plus out_of_order_notice_n drive
`timescale 1ns/100ps
module bdi_agent_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  bdi_link_if.agt_mp link,
  // user transmit side
  input wire logic tx_valid,
  input wire logic [bdi_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // user receive side
  output logic [bdi_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  // cannot complete in order, active high level
  input wire logic out_of_order_notice_n_req
);

  bdi_xfer_core u_core (
    .clk(clk),
    .rst_b(rst_b),
    .bus_clk(link.bus_clk),
    .in_data_n(link.data_line_n),
    .in_flag_n(link.group_invert_flag_n),
    .in_stbp_n(link.group_strobe_pos_n),
    .in_stbn_n(link.group_strobe_neg_n),
    .in_occ_n(link.data_bus_occupied_n),
    .in_vld_n(link.transfer_valid_n),
    .out_data_n(link.agt_data_n),
    .out_flag_n(link.agt_flag_n),
    .out_stbp_n(link.agt_stbp_n),
    .out_stbn_n(link.agt_stbn_n),
    .out_occ_n(link.agt_occ_n),
    .out_vld_n(link.agt_vld_n),
    .out_oe(link.agt_oe),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      link.agt_out_of_order_notice_n_n <= bdi_pkg::LINE_IDLE;
    else
      link.agt_out_of_order_notice_n_n <= ~out_of_order_notice_n_req;
  end

endmodule

// ===== sim/bdi_link_monitor.sv
// concurrent checks on the resolved link between both ends
`timescale 1ns/100ps
module bdi_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // per-end drive
  input wire logic cpu_oe,
  input wire logic agt_oe,
  input wire logic cpu_occ_n,
  input wire logic agt_occ_n,
  // resolved wires
  input wire logic [bdi_pkg::DATA_W-1:0] data_line_n,
  input wire logic [bdi_pkg::NGRP-1:0] group_invert_flag_n,
  input wire logic [bdi_pkg::NGRP-1:0] group_strobe_pos_n,
  input wire logic [bdi_pkg::NGRP-1:0] group_strobe_neg_n,
  input wire logic data_bus_occupied_n,
  input wire logic transfer_valid_n
);
  logic [bdi_pkg::NGRP-1:0] sp_q;
  logic [bdi_pkg::NGRP-1:0] sn_q;
  logic [bdi_pkg::NGRP-1:0] fall;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************
  // strobe edge finder
  // ****************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sp_q <= '1;
      sn_q <= '1;
    end
    else
    begin
      sp_q <= group_strobe_pos_n;
      sn_q <= group_strobe_neg_n;
    end
  assign fall = (sp_q & ~group_strobe_pos_n) | (sn_q & ~group_strobe_neg_n);

  // ****************************
  // ownership and slot checks
  // ****************************
  sequence s_wait_vld;
    !data_bus_occupied_n throughout ##[1:14] !transfer_valid_n;
  endsequence
  sequence s_start;
    $rose(cpu_oe) || $rose(agt_oe);
  endsequence

  a_cpu_busy_held: assert property (cpu_oe |-> !cpu_occ_n)
    else $error("cpu owns bus without busy");
  a_agt_busy_held: assert property (agt_oe |-> !agt_occ_n)
    else $error("agent owns bus without busy");
  a_single_owner: assert property (!(cpu_oe && agt_oe))
    else $error("both ends drive the bus");
  a_start_free: assert property (s_start |-> $past(data_bus_occupied_n))
    else $error("drive began while bus busy");
  a_grant_flow: assert property (s_start |-> s_wait_vld)
    else $error("owned bus never carried data");
  a_valid_owned: assert property (!transfer_valid_n |-> !data_bus_occupied_n)
    else $error("valid without owner");
  a_strobe_valid: assert property (|fall |-> !transfer_valid_n)
    else $error("strobe outside valid clock");
  a_same_slot: assert property (|fall |-> $stable(data_line_n)
    && $stable(group_invert_flag_n))
    else $error("flag or data moved at strobe");
  a_release_clean: assert property ($fell(cpu_oe)
    |-> data_bus_occupied_n && transfer_valid_n)
    else $error("release left lines low");

  // the reference is the level last strobed, all ones while bus is free
  for (genvar g = 0; g < bdi_pkg::NGRP; g++)
  begin : g_grp
    logic [15:0] ref_q;
    logic [4:0] cnt;
    assign cnt = 5'($countones(data_line_n[16*g+:16] ^ ref_q));
    always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
        ref_q <= 16'hFFFF;
      else if (data_bus_occupied_n)
        ref_q <= 16'hFFFF;
      else if (fall[g])
        ref_q <= data_line_n[16*g+:16];
    a_bal_toggles: assert property (fall[g] |->
      (group_invert_flag_n[g] ? cnt <= 8 : cnt < 8))
      else $error("inversion choice wrong");
  end
endmodule

// ===== sim/tb_bus_data_inversion_coder.sv
// bench joining both coder ends across the shared link
`timescale 1ns/100ps
module tb_bus_data_inversion_coder;
  logic clk = 1'b0;
  logic rst_b;
  logic out_of_order_notice_n_req;
  logic tv [2];
  logic tl [2];
  logic [63:0] td [2];
  logic cpu_rdy, agt_rdy, cpu_rv, agt_rv, out_of_order_notice_n_seen;
  logic [63:0] cpu_rd, agt_rd, dec, we;
  logic [3:0] sp = 4'hF;
  logic [3:0] sn = 4'hF;
  logic [3:0] fp, fn;
  logic [15:0] seed = 16'h003C;
  logic [63:0] qa [$];
  logic [63:0] qc [$];
  logic [63:0] wq [$];
  int slot;
  int fails = 0;
  int total_checks = 0;
  // after idle: no toggle, full toggle, exact tie
  logic [63:0] fixed [3] = '{64'h0000_0000_0000_0000,
    64'hFFFF_FFFF_FFFF_FFFF, 64'h00FF_00FF_00FF_00FF};

  bdi_link_if link ();

  bdi_cpu_end u_bdi_cpu_end (.clk(clk), .rst_b(rst_b), .link(link),
    .tx_valid(tv[0]), .tx_data(td[0]), .tx_last(tl[0]),
    .tx_ready(cpu_rdy), .rx_data(cpu_rd), .rx_valid(cpu_rv),
    .out_of_order_notice_n_seen(out_of_order_notice_n_seen));
  bdi_agent_end u_bdi_agent_end (.clk(clk), .rst_b(rst_b), .link(link),
    .tx_valid(tv[1]), .tx_data(td[1]), .tx_last(tl[1]),
    .tx_ready(agt_rdy), .rx_data(agt_rd), .rx_valid(agt_rv),
    .out_of_order_notice_n_req(out_of_order_notice_n_req));
  bdi_link_monitor u_bdi_link_monitor (.clk(clk), .rst_b(rst_b),
    .cpu_oe(link.cpu_oe), .agt_oe(link.agt_oe),
    .cpu_occ_n(link.cpu_occ_n), .agt_occ_n(link.agt_occ_n),
    .data_line_n(link.data_line_n),
    .group_invert_flag_n(link.group_invert_flag_n),
    .group_strobe_pos_n(link.group_strobe_pos_n),
    .group_strobe_neg_n(link.group_strobe_neg_n),
    .data_bus_occupied_n(link.data_bus_occupied_n),
    .transfer_valid_n(link.transfer_valid_n));

  // ****************************
  // clocks and helpers
  // ****************************
  always #12.5 clk = ~clk;

  function logic [63:0] next_word();
    for (int i = 0; i < 4; i++)
    begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      next_word[16*i+:16] = seed;
    end
  endfunction

  task cmp64(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cmp1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // request held until the ready pulse is seen; caller drops valid
  task send(input int e, input logic [63:0] w, input logic last);
    int n;
    n = 0;
    if (e == 1)
      qc.push_back(w);
    else
      qa.push_back(w);
    wq.push_back(w);
    tv[e] = 1'b1;
    td[e] = w;
    tl[e] = last;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((e == 1 ? agt_rdy : cpu_rdy) !== 1'b1 && n < 100);
    cmp1("tx ready", 1'b1, e == 1 ? agt_rdy : cpu_rdy);
  endtask

  task burst(input int e, input int n);
    for (int i = 0; i < n; i++)
    begin
      send(e, i < 3 ? fixed[i] : next_word(), 1'(i == n - 1));
      if (i == 3 && n > 4)
      begin
        tv[e] = 1'b0;
        repeat (20) @(negedge clk);
      end
    end
    tv[e] = 1'b0;
    repeat (40) @(negedge clk);
  endtask

  // ****************************
  // result watcher
  // ****************************
  always @(negedge clk)
  begin
    if (agt_rv === 1'b1)
      cmp64("agent rx", qa.size() ? qa.pop_front() : 'x, agt_rd);
    if (cpu_rv === 1'b1)
      cmp64("cpu rx", qc.size() ? qc.pop_front() : 'x, cpu_rd);
    fp = sp & ~link.group_strobe_pos_n;
    fn = sn & ~link.group_strobe_neg_n;
    if (link.data_bus_occupied_n === 1'b1)
      slot = 0;
    if (fp[0] | fn[0])
    begin
      we = wq.size() ? wq.pop_front() : 'x;
      for (int g = 0; g < 4; g++)
        dec[16*g+:16] = link.group_invert_flag_n[g]
          ? ~link.data_line_n[16*g+:16] : link.data_line_n[16*g+:16];
      cmp64("wire word", we, dec);
      cmp1("pos strobe", 1'(slot % 2 == 0), fp[0]);
      cmp1("group strobes", 1'b1, &(fp | fn));
      slot++;
    end
    sp = link.group_strobe_pos_n;
    sn = link.group_strobe_neg_n;
  end

  // ****************************
  // main sequence
  // ****************************
  initial
  begin
    link.bus_clk = 1'b0;
    #7.3;
    forever #100 link.bus_clk = ~link.bus_clk;
  end

  initial
  begin
    rst_b = 1'b0;
    out_of_order_notice_n_req = 1'b0;
    tv = '{1'b0, 1'b0};
    tl = '{1'b0, 1'b0};
    td = '{64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000};
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    burst(0, 8);
    burst(1, 4);
    burst(0, 1);
    burst(1, 8);
    for (int v = 0; v < 2; v++)
    begin
      out_of_order_notice_n_req = 1'(1 - v);
      repeat (5) @(negedge clk);
      cmp1("out_of_order_notice_n wire", 1'(v), link.out_of_order_notice_n);
      cmp1("out_of_order_notice_n seen", 1'(1 - v), out_of_order_notice_n_seen);
    end
    cmp1("drained", 1'b1, 1'(qa.size() + qc.size() + wq.size() == 0));
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
